// [core/lsfr_debounce.sv]
`timescale 1ns/100ps
`default_nettype none
module lsfr_debounce (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	input  wire logic        rawIn,
	input  wire logic [31:0] interval,
	output logic             stateOut
);
	logic        state_r;
	logic        state_nxt;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = 32'h0;
		if (rawIn != state_r) begin
			// Any bounce back to the old level clears the count
			if (cnt_r >= interval) begin
				state_nxt = rawIn;
			end else begin
				cnt_nxt = cnt_r + 32'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= 1'b0;
			cnt_r   <= 32'h0;
		end else if (ce) begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	assign stateOut = state_r;
endmodule
`default_nettype wire

// [core/lsfr_pkg.sv]
package lsfr_pkg;
	localparam logic [7:0]  CMD_LOOP_WR     = 8'hc2;
	localparam logic [7:0]  CMD_LOOP_RD     = 8'hc3;
	localparam logic [7:0]  CMD_FEED_WR     = 8'hc6;
	localparam logic [7:0]  CMD_FEED_RD     = 8'hc7;
	localparam logic [7:0]  CMD_GAIN_WR     = 8'hca;
	localparam logic [7:0]  CMD_GAIN_RD     = 8'hcb;
	localparam logic [7:0]  CMD_SAMPLE_RD   = 8'hcd;

	localparam logic [2:0]  LEN_LOOP        = 3'h4;
	localparam logic [2:0]  LEN_FEED        = 3'h2;
	localparam logic [2:0]  LEN_GAIN        = 3'h1;
	localparam logic [2:0]  LEN_SAMPLE      = 3'h2;

	localparam logic [31:0] LOOP_RESET      = 32'h1b84b30e;
	localparam logic [15:0] FEED_RESET      = 16'h1108;
	localparam logic [7:0]  GAIN_RESET      = 8'h00;
	localparam logic [15:0] SAMPLE_RESET    = 16'h0000;
	localparam logic [31:0] LOOP_WR_MASK    = 32'h3fffff1f;
	localparam logic [15:0] FEED_WR_MASK    = 16'h7fdf;

	localparam int          GK_THR_LSB      = 27;
	localparam int          HOOK_THR_LSB    = 24;
	localparam int          GK_DEB_LSB      = 21;
	localparam int          HOOK_DEB_LSB    = 16;
	localparam int          RT_METHOD_BIT   = 15;
	localparam int          RT_THR_LSB      = 8;
	localparam int          RING_ILIM_LSB   = 0;
	localparam int          VOC_SHIFT_BIT   = 14;
	localparam int          LONG_IMP_BIT    = 13;
	localparam int          VOC_LSB         = 10;
	localparam int          BAT_OFS_LSB     = 6;
	localparam int          ACT_ILIM_LSB    = 0;

	localparam int unsigned CLK_HZ          = 125000000;
	localparam int unsigned GK_DEB_STEP_US  = 4000;
	localparam int unsigned HOOK_DEB_STEP_US = 2000;
	localparam int unsigned BAT_SWITCH_US   = 2000;
	localparam int unsigned IRQ_NB_NS       = 54000;
	localparam int unsigned IRQ_WB_NS       = 26000;
	localparam int unsigned SAMPLE_MAX_HZ   = 8000;

	localparam int unsigned GK_DEB_STEP_CYC   = int'((longint'(GK_DEB_STEP_US) * CLK_HZ + 999999) / 1000000);
	localparam int unsigned HOOK_DEB_STEP_CYC = int'((longint'(HOOK_DEB_STEP_US) * CLK_HZ + 999999) / 1000000);
	localparam int unsigned BAT_SWITCH_CYC    = int'((longint'(BAT_SWITCH_US) * CLK_HZ + 999999) / 1000000);
	localparam int unsigned IRQ_NB_CYC        = int'((longint'(IRQ_NB_NS) * CLK_HZ + 999999999) / 1000000000);
	localparam int unsigned IRQ_WB_CYC        = int'((longint'(IRQ_WB_NS) * CLK_HZ + 999999999) / 1000000000);
	localparam int unsigned SAMPLE_BASE_CYC   = CLK_HZ / SAMPLE_MAX_HZ;

	typedef enum logic [2:0] {
		LSFR_IDLE = 3'b001,
		LSFR_WR   = 3'b010,
		LSFR_RD   = 3'b100
	} lsfr_state_t;
endpackage

// [core/lsfr_regs.sv]
// Functional notes
// - Ground-key threshold, 3 bits, 6 mA steps from zero, resets to 011.
// - Hook threshold, 3 bits, 8 mA plus 1 mA steps, resets to 011.
// - Ground-key debounce, 3 bits, 4 ms steps, resets to 100.
// - Hook debounce, 5 bits, 2 ms steps, resets to 00100; host avoids below 12 ms.
// - Ring-trip method bit: 0 DC biased, 1 AC; resets to AC.
// - Ring-trip threshold, 7 bits, 0.5 mA steps, resets to 0110011.
// - Ringing current limit, 5 bits, 50 mA plus 2 mA steps, resets to 01110.
// - Open-circuit voltage, 3 V steps from 36 V or 12 V by shift; resets 100.
// - Longitudinal impedance bit: 0 means 100 ohm per leg, 1 means 50.
// - Battery-switch offset, 4 bits, 1.5 V plus 0.375 V steps, resets 0100.
// - Change battery only after comparator condition persists longer than 2 ms.
// - Active current limit, 5 bits, 18 mA plus 1 mA steps, resets 01000.
// - Scaling gain is two's complement; zero removes the scaling network.
// - Sample register: companded byte high, or full 16-bit linear sample.
// - Channel chosen by enable selection; both or none returns channel 1.
// - Single-sample behaviour only while test-buffer mode stays cleared.
// - Test mode linear data is signed 1.15, negative voltages shown positive.
// - Update at programmed rate; when armed each update sets flag and interrupt.
// - Test data also goes to PCM output unless transmit path cut is set.
// - Armed interrupt clears after 54 us, 26 us wideband, or on sample read.
`timescale 1ns/100ps
`default_nettype none
module lsfr_regs #(
	parameter int unsigned GK_STEP_CYC     = lsfr_pkg::GK_DEB_STEP_CYC,
	parameter int unsigned HOOK_STEP_CYC   = lsfr_pkg::HOOK_DEB_STEP_CYC,
	parameter int unsigned BAT_CYC         = lsfr_pkg::BAT_SWITCH_CYC,
	parameter int unsigned IRQ_NB_CYC      = lsfr_pkg::IRQ_NB_CYC,
	parameter int unsigned IRQ_WB_CYC      = lsfr_pkg::IRQ_WB_CYC,
	parameter int unsigned SAMPLE_BASE_CYC = lsfr_pkg::SAMPLE_BASE_CYC
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        ce,
	input  wire logic [7:0]  hostInData,
	input  wire logic        hostInValid,
	output logic             hostInReady,
	output logic      [7:0]  hostOutData,
	output logic             hostOutValid,
	input  wire logic        hostOutReady,
	input  wire logic        hookDetRaw,
	input  wire logic        gkeyDetRaw,
	input  wire logic        feedBelowUpper,
	input  wire logic        feedAboveLower,
	input  wire logic        testBufferMode,
	input  wire logic        dataReadyIrqArm,
	input  wire logic [2:0]  converterDataRate,
	input  wire logic        wideband,
	input  wire logic        linearMode,
	input  wire logic [1:0]  channelEnableSelect,
	input  wire logic        transmitPathCut,
	input  wire logic [15:0] sampleCh1,
	input  wire logic [15:0] sampleCh2,
	output logic      [2:0]  groundKeyThreshold,
	output logic      [2:0]  hookThreshold,
	output logic      [2:0]  groundKeyDebounce,
	output logic      [4:0]  hookDebounce,
	output logic             ringTripMethod,
	output logic      [6:0]  ringTripThreshold,
	output logic      [4:0]  ringingCurrentLimit,
	output logic             feedVoltageRangeShift,
	output logic      [2:0]  openCircuitFeedVoltage,
	output logic             longitudinalImpedanceSel,
	output logic      [3:0]  batterySwitchOffset,
	output logic      [4:0]  activeCurrentLimit,
	output logic      [7:0]  impedanceScalingGain,
	output logic             scalingBypass,
	output logic             hookState,
	output logic             groundKeyState,
	output logic             lowBattery,
	output logic             sampleReadyFlag,
	output logic             dataReadyIrq,
	output logic      [15:0] pcmTransmitOut,
	output logic             pcmTransmitValid
);
	generate
		if (SAMPLE_BASE_CYC < 32 || IRQ_NB_CYC < 1 || IRQ_WB_CYC < 1 || BAT_CYC < 1) begin : g_chk
			$error("lsfr_regs: timing parameters out of range");
		end
	endgenerate

	function automatic logic [2:0] cmdLen(input logic [7:0] c);
		unique case (c)
			lsfr_pkg::CMD_LOOP_WR, lsfr_pkg::CMD_LOOP_RD: cmdLen = lsfr_pkg::LEN_LOOP;
			lsfr_pkg::CMD_FEED_WR, lsfr_pkg::CMD_FEED_RD: cmdLen = lsfr_pkg::LEN_FEED;
			lsfr_pkg::CMD_GAIN_WR, lsfr_pkg::CMD_GAIN_RD: cmdLen = lsfr_pkg::LEN_GAIN;
			lsfr_pkg::CMD_SAMPLE_RD:                      cmdLen = lsfr_pkg::LEN_SAMPLE;
			default:                                      cmdLen = 3'h0;
		endcase
	endfunction

	// Pin synchronisers: three stages, accept once stages two and three agree
	logic [3:0] syncA_r;
	logic [3:0] syncB_r;
	logic [3:0] syncC_r;
	logic [3:0] pinFilt_r;
	logic [3:0] pinFilt_nxt;

	always_comb begin
		pinFilt_nxt = (syncB_r & syncC_r) | (pinFilt_r & (syncB_r ^ syncC_r));
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			syncA_r   <= 4'h0;
			syncB_r   <= 4'h0;
			syncC_r   <= 4'h0;
			pinFilt_r <= 4'h0;
		end else if (ce) begin
			syncA_r   <= {feedAboveLower, feedBelowUpper, gkeyDetRaw, hookDetRaw};
			syncB_r   <= syncA_r;
			syncC_r   <= syncB_r;
			pinFilt_r <= pinFilt_nxt;
		end
	end

	// Register file and command engine
	lsfr_pkg::lsfr_state_t state_r;
	lsfr_pkg::lsfr_state_t state_nxt;
	logic [7:0]  cmd_r;
	logic [7:0]  cmd_nxt;
	logic [2:0]  cnt_r;
	logic [2:0]  cnt_nxt;
	logic [31:0] shift_r;
	logic [31:0] shift_nxt;
	logic [31:0] loop_r;
	logic [31:0] loop_nxt;
	logic [15:0] feed_r;
	logic [15:0] feed_nxt;
	logic [7:0]  gain_r;
	logic [7:0]  gain_nxt;
	logic        bypass_r;
	logic        bypass_nxt;
	logic        inReady_r;
	logic        inReady_nxt;
	logic        sampleRead;
	logic        bufInValid;
	logic        bufInReady;
	logic [31:0] wrWord;
	logic [15:0] sample_r;

	always_comb begin
		state_nxt  = state_r;
		cmd_nxt    = cmd_r;
		cnt_nxt    = cnt_r;
		shift_nxt  = shift_r;
		loop_nxt   = loop_r;
		feed_nxt   = feed_r;
		gain_nxt   = gain_r;
		sampleRead = 1'b0;
		bufInValid = 1'b0;
		wrWord     = {shift_r[23:0], hostInData};
		unique case (state_r)
			lsfr_pkg::LSFR_IDLE: begin
				if (hostInValid && inReady_r) begin
					cmd_nxt = hostInData;
					cnt_nxt = 3'h0;
					unique case (hostInData)
						lsfr_pkg::CMD_LOOP_WR, lsfr_pkg::CMD_FEED_WR, lsfr_pkg::CMD_GAIN_WR: begin
							state_nxt = lsfr_pkg::LSFR_WR;
						end
						lsfr_pkg::CMD_LOOP_RD: begin
							state_nxt = lsfr_pkg::LSFR_RD;
							shift_nxt = loop_r;
						end
						lsfr_pkg::CMD_FEED_RD: begin
							state_nxt = lsfr_pkg::LSFR_RD;
							shift_nxt = {feed_r, 16'h0000};
						end
						lsfr_pkg::CMD_GAIN_RD: begin
							state_nxt = lsfr_pkg::LSFR_RD;
							shift_nxt = {gain_r, 24'h000000};
						end
						lsfr_pkg::CMD_SAMPLE_RD: begin
							state_nxt  = lsfr_pkg::LSFR_RD;
							shift_nxt  = {sample_r, 16'h0000};
							sampleRead = 1'b1;
						end
						default: begin
							// Unknown codes are dropped; the next byte is taken as a command
						end
					endcase
				end
			end
			lsfr_pkg::LSFR_WR: begin
				if (hostInValid && inReady_r) begin
					shift_nxt = wrWord;
					if (cnt_r == cmdLen(cmd_r) - 3'h1) begin
						state_nxt = lsfr_pkg::LSFR_IDLE;
						// Reserved positions are stored as zero
						if (cmd_r == lsfr_pkg::CMD_LOOP_WR) begin
							loop_nxt = wrWord & lsfr_pkg::LOOP_WR_MASK;
						end else if (cmd_r == lsfr_pkg::CMD_FEED_WR) begin
							feed_nxt = wrWord[15:0] & lsfr_pkg::FEED_WR_MASK;
						end else begin
							gain_nxt = wrWord[7:0];
						end
					end else begin
						cnt_nxt = cnt_r + 3'h1;
					end
				end
			end
			lsfr_pkg::LSFR_RD: begin
				bufInValid = 1'b1;
				if (bufInReady) begin
					shift_nxt = {shift_r[23:0], 8'h00};
					if (cnt_r == cmdLen(cmd_r) - 3'h1) begin
						state_nxt = lsfr_pkg::LSFR_IDLE;
					end else begin
						cnt_nxt = cnt_r + 3'h1;
					end
				end
			end
			default: begin
				state_nxt = lsfr_pkg::LSFR_IDLE;
			end
		endcase
		inReady_nxt = (state_nxt != lsfr_pkg::LSFR_RD);
		bypass_nxt  = (gain_nxt == 8'h00);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r   <= lsfr_pkg::LSFR_IDLE;
			cmd_r     <= 8'h00;
			cnt_r     <= 3'h0;
			shift_r   <= 32'h0;
			loop_r    <= lsfr_pkg::LOOP_RESET;
			feed_r    <= lsfr_pkg::FEED_RESET;
			gain_r    <= lsfr_pkg::GAIN_RESET;
			bypass_r  <= 1'b1;
			inReady_r <= 1'b1;
		end else if (ce) begin
			state_r   <= state_nxt;
			cmd_r     <= cmd_nxt;
			cnt_r     <= cnt_nxt;
			shift_r   <= shift_nxt;
			loop_r    <= loop_nxt;
			feed_r    <= feed_nxt;
			gain_r    <= gain_nxt;
			bypass_r  <= bypass_nxt;
			inReady_r <= inReady_nxt;
		end
	end

	lsfr_skid_buf #(
		.WIDTH    (8)
	) u_outBuf (
		.clk      (clk),
		.arst_n   (arst_n),
		.ce       (ce),
		.inData   (shift_r[31:24]),
		.inValid  (bufInValid),
		.inReady  (bufInReady),
		.outData  (hostOutData),
		.outValid (hostOutValid),
		.outReady (hostOutReady)
	);

	// Debounce: interval is field times step; field zero follows raw at once
	logic [31:0] hookInterval;
	logic [31:0] gkeyInterval;
	assign hookInterval = 32'(loop_r[lsfr_pkg::HOOK_DEB_LSB +: 5]) * HOOK_STEP_CYC;
	assign gkeyInterval = 32'(loop_r[lsfr_pkg::GK_DEB_LSB +: 3]) * GK_STEP_CYC;

	lsfr_debounce u_hookDeb (
		.clk      (clk),
		.arst_n   (arst_n),
		.ce       (ce),
		.rawIn    (pinFilt_r[0]),
		.interval (hookInterval),
		.stateOut (hookState)
	);

	lsfr_debounce u_gkeyDeb (
		.clk      (clk),
		.arst_n   (arst_n),
		.ce       (ce),
		.rawIn    (pinFilt_r[1]),
		.interval (gkeyInterval),
		.stateOut (groundKeyState)
	);

	// Battery selection with timed hysteresis on both directions
	logic        lowBat_r;
	logic        lowBat_nxt;
	logic [31:0] batCnt_r;
	logic [31:0] batCnt_nxt;

	always_comb begin
		lowBat_nxt = lowBat_r;
		batCnt_nxt = 32'h0;
		if (lowBat_r ? pinFilt_r[3] : pinFilt_r[2]) begin
			if (batCnt_r >= BAT_CYC) begin
				lowBat_nxt = !lowBat_r;
			end else begin
				batCnt_nxt = batCnt_r + 32'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lowBat_r <= 1'b0;
			batCnt_r <= 32'h0;
		end else if (ce) begin
			lowBat_r <= lowBat_nxt;
			batCnt_r <= batCnt_nxt;
		end
	end

	// Sample capture, ready flag and interrupt
	logic [31:0] rateCnt_r;
	logic [31:0] rateCnt_nxt;
	logic [31:0] period;
	logic [2:0]  rateCode;
	logic        update;
	logic [15:0] pick;
	logic [15:0] sample_nxt;
	logic        flag_r;
	logic        flag_nxt;
	logic        irq_r;
	logic        irq_nxt;
	logic [31:0] irqCnt_r;
	logic [31:0] irqCnt_nxt;
	logic [15:0] pcm_r;
	logic [15:0] pcm_nxt;
	logic        pcmValid_r;
	logic        pcmValid_nxt;

	always_comb begin
		// Reserved rate codes run at the slowest defined rate
		rateCode    = (converterDataRate > 3'h4) ? 3'h4 : converterDataRate;
		period      = (SAMPLE_BASE_CYC >> wideband) << rateCode;
		update      = (rateCnt_r >= period - 32'h1);
		rateCnt_nxt = update ? 32'h0 : rateCnt_r + 32'h1;
		pick        = (channelEnableSelect == 2'b10) ? sampleCh2 : sampleCh1;
		if (!linearMode) begin
			pick[7:0] = 8'h00;
		end
		sample_nxt   = sample_r;
		pcm_nxt      = pcm_r;
		pcmValid_nxt = 1'b0;
		flag_nxt     = flag_r && !sampleRead;
		irq_nxt      = irq_r;
		irqCnt_nxt   = irqCnt_r;
		if (irq_r) begin
			if (sampleRead || irqCnt_r <= 32'h1) begin
				irq_nxt = 1'b0;
			end
			irqCnt_nxt = irqCnt_r - 32'h1;
		end
		if (update && !testBufferMode) begin
			sample_nxt   = pick;
			pcm_nxt      = pick;
			pcmValid_nxt = !transmitPathCut;
			if (dataReadyIrqArm) begin
				flag_nxt   = 1'b1;
				irq_nxt    = 1'b1;
				irqCnt_nxt = wideband ? IRQ_WB_CYC : IRQ_NB_CYC;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rateCnt_r  <= 32'h0;
			sample_r   <= lsfr_pkg::SAMPLE_RESET;
			flag_r     <= 1'b0;
			irq_r      <= 1'b0;
			irqCnt_r   <= 32'h0;
			pcm_r      <= 16'h0000;
			pcmValid_r <= 1'b0;
		end else if (ce) begin
			rateCnt_r  <= rateCnt_nxt;
			sample_r   <= sample_nxt;
			flag_r     <= flag_nxt;
			irq_r      <= irq_nxt;
			irqCnt_r   <= irqCnt_nxt;
			pcm_r      <= pcm_nxt;
			pcmValid_r <= pcmValid_nxt;
		end
	end

	assign hostInReady              = inReady_r;
	assign groundKeyThreshold       = loop_r[lsfr_pkg::GK_THR_LSB +: 3];
	assign hookThreshold            = loop_r[lsfr_pkg::HOOK_THR_LSB +: 3];
	assign groundKeyDebounce        = loop_r[lsfr_pkg::GK_DEB_LSB +: 3];
	assign hookDebounce             = loop_r[lsfr_pkg::HOOK_DEB_LSB +: 5];
	assign ringTripMethod           = loop_r[lsfr_pkg::RT_METHOD_BIT];
	assign ringTripThreshold        = loop_r[lsfr_pkg::RT_THR_LSB +: 7];
	assign ringingCurrentLimit      = loop_r[lsfr_pkg::RING_ILIM_LSB +: 5];
	assign feedVoltageRangeShift    = feed_r[lsfr_pkg::VOC_SHIFT_BIT];
	assign openCircuitFeedVoltage   = feed_r[lsfr_pkg::VOC_LSB +: 3];
	assign longitudinalImpedanceSel = feed_r[lsfr_pkg::LONG_IMP_BIT];
	assign batterySwitchOffset      = feed_r[lsfr_pkg::BAT_OFS_LSB +: 4];
	assign activeCurrentLimit       = feed_r[lsfr_pkg::ACT_ILIM_LSB +: 5];
	assign impedanceScalingGain     = gain_r;
	assign scalingBypass            = bypass_r;
	assign lowBattery               = lowBat_r;
	assign sampleReadyFlag          = flag_r;
	assign dataReadyIrq             = irq_r;
	assign pcmTransmitOut           = pcm_r;
	assign pcmTransmitValid         = pcmValid_r;
endmodule
`default_nettype wire

// [core/lsfr_skid_buf.sv]
`timescale 1ns/100ps
`default_nettype none
module lsfr_skid_buf #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             arst_n,
	input  wire logic             ce,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	generate
		if (WIDTH < 1) begin : g_chk
			$error("lsfr_skid_buf: WIDTH must be at least 1");
		end
	endgenerate

	// Head always in slot 0 so the output is a plain register
	logic [WIDTH-1:0] head_r;
	logic [WIDTH-1:0] head_nxt;
	logic [WIDTH-1:0] tail_r;
	logic [WIDTH-1:0] tail_nxt;
	logic [1:0]       cnt_r;
	logic [1:0]       cnt_nxt;
	logic             pop;
	logic             push;

	always_comb begin
		pop      = outReady && (cnt_r != 2'h0);
		push     = inValid && (cnt_r != 2'h2);
		head_nxt = head_r;
		tail_nxt = tail_r;
		cnt_nxt  = cnt_r;
		if (pop) begin
			head_nxt = tail_r;
		end
		if (push) begin
			if ((cnt_r == 2'h0) || ((cnt_r == 2'h1) && pop)) begin
				head_nxt = inData;
			end else begin
				tail_nxt = inData;
			end
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 2'h1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 2'h1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			head_r <= '0;
			tail_r <= '0;
			cnt_r  <= 2'h0;
		end else if (ce) begin
			head_r <= head_nxt;
			tail_r <= tail_nxt;
			cnt_r  <= cnt_nxt;
		end
	end

	assign outData  = head_r;
	assign outValid = (cnt_r != 2'h0);
	assign inReady  = (cnt_r != 2'h2);
endmodule
`default_nettype wire

// [sim/lsfr_host.sv]
`timescale 1ns/100ps
`default_nettype none
module lsfr_host (
	input  wire logic       clk,
	input  wire logic       hostInReady,
	input  wire logic [7:0] hostOutData,
	input  wire logic       hostOutValid,
	output logic      [7:0] hostInData,
	output logic            hostInValid,
	output logic            hostOutReady
);
	initial begin
		hostInData = 8'h00;
		hostInValid = 1'b0;
		hostOutReady = 1'b0;
	end
	task automatic put(input logic [7:0] b);
		@(negedge clk);
		hostInValid = 1'b1;
		hostInData = b;
		while (hostInReady !== 1'b1) @(negedge clk);
		@(posedge clk);
	endtask
	// Released bus shows the inverse so a stale byte cannot pass
	task automatic idle();
		@(negedge clk);
		hostInValid = 1'b0;
		hostInData = ~hostInData;
	endtask
	task automatic wr(input logic [7:0] c, input logic [31:0] d, input int n);
		put(c);
		for (int i = n - 1; i >= 0; i--) put(d[8*i+:8]);
		idle();
	endtask
	// Random stalls let the output buffer fill up
	task automatic rd(input logic [7:0] c, input int n, output logic [31:0] d);
		d = 32'h0;
		put(c);
		idle();
		for (int i = 0; i < n; i++) begin
			do begin
				@(negedge clk);
				hostOutReady = 1'($urandom_range(1, 0));
			end while (!(hostOutReady && hostOutValid === 1'b1));
			d = {d[23:0], hostOutData};
			@(posedge clk);
		end
		@(negedge clk);
		hostOutReady = 1'b0;
	endtask
endmodule
`default_nettype wire

// [sim/lsfr_regs_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module lsfr_regs_asserts #(
	parameter int unsigned HOOK_STEP_CYC = 4,
	parameter int unsigned BAT_CYC       = 10,
	parameter int unsigned IRQ_NB_CYC    = 20,
	parameter int unsigned IRQ_WB_CYC    = 10
) (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic [7:0] hostInData,
	input wire logic       hostInValid,
	input wire logic       hostInReady,
	input wire logic       hookDetRaw,
	input wire logic       feedBelowUpper,
	input wire logic       feedAboveLower,
	input wire logic       testBufferMode,
	input wire logic       dataReadyIrqArm,
	input wire logic       wideband,
	input wire logic       transmitPathCut,
	input wire logic [4:0] hookDebounce,
	input wire logic [7:0] impedanceScalingGain,
	input wire logic       scalingBypass,
	input wire logic       hookState,
	input wire logic       lowBattery,
	input wire logic       sampleReadyFlag,
	input wire logic       dataReadyIrq,
	input wire logic       pcmTransmitValid
);
	// Run lengths at the hook and battery comparator raw pins and of dataReadyIrq; valid only while ce stays high
	logic [15:0] hiCnt_r, belCnt_r, abvCnt_r, irqCnt_r;
	logic        rdCmd;
	assign rdCmd = hostInValid && hostInReady && hostInData == 8'hcd;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hiCnt_r <= 16'h0000;
			belCnt_r <= 16'h0000;
			abvCnt_r <= 16'h0000;
			irqCnt_r <= 16'h0000;
		end else begin
			hiCnt_r <= hookDetRaw ? hiCnt_r + 16'h0001 : 16'h0000;
			belCnt_r <= feedBelowUpper ? belCnt_r + 16'h0001 : 16'h0000;
			abvCnt_r <= feedAboveLower ? abvCnt_r + 16'h0001 : 16'h0000;
			irqCnt_r <= dataReadyIrq ? irqCnt_r + 16'h0001 : 16'h0000;
		end
	end
	default clocking dc @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_GAIN_BYPASS:
		assert property (scalingBypass == (impedanceScalingGain == 8'h00)) else $error("bypass wrong");
	AST_HOOK_DEB:
		assert property ($rose(hookState) |-> hiCnt_r >= hookDebounce * HOOK_STEP_CYC) else $error("hook early");
	AST_BAT_LOW:
		assert property ($rose(lowBattery) |-> belCnt_r > BAT_CYC) else $error("low battery early");
	AST_BAT_MED:
		assert property ($fell(lowBattery) |-> abvCnt_r > BAT_CYC) else $error("medium battery early");
	AST_IRQ_END:
		assert property ($fell(dataReadyIrq) |-> irqCnt_r == ($past(wideband) ? IRQ_WB_CYC : IRQ_NB_CYC)
			|| $past(rdCmd) || $past(rdCmd, 2)) else $error("irq length wrong");
	AST_IRQ_ARM:
		assert property ($rose(dataReadyIrq) |-> sampleReadyFlag && $past(dataReadyIrqArm)) else $error("irq unarmed");
	AST_PCM_CUT:
		assert property (pcmTransmitValid |-> !$past(transmitPathCut) && !$past(testBufferMode)) else $error("pcm sent");
	AST_PCM_PULSE:
		assert property (pcmTransmitValid |=> !pcmTransmitValid) else $error("pcm pulse long");
endmodule
`default_nettype wire

// [sim/lsfr_regs_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module lsfr_regs_tb_top;
	logic clk = 1'b0, arst_n = 1'b0, ce = 1'b1, testBufferMode = 1'b0;
	logic hookDetRaw = 1'b0, gkeyDetRaw = 1'b0, feedBelowUpper = 1'b0, feedAboveLower = 1'b0;
	logic dataReadyIrqArm = 1'b0, wideband = 1'b0, linearMode = 1'b0, transmitPathCut = 1'b0;
	logic [2:0]  converterDataRate = 3'h0;
	logic [1:0]  channelEnableSelect = 2'h0;
	logic [15:0] sampleCh1 = 16'h0000, sampleCh2 = 16'h0000, pcmTransmitOut;
	logic [7:0]  hostInData, hostOutData, impedanceScalingGain;
	logic        hostInValid, hostInReady, hostOutValid, hostOutReady, ringTripMethod, feedVoltageRangeShift;
	logic [2:0]  groundKeyThreshold, hookThreshold, groundKeyDebounce, openCircuitFeedVoltage;
	logic [4:0]  hookDebounce, ringingCurrentLimit, activeCurrentLimit;
	logic [6:0]  ringTripThreshold;
	logic [3:0]  batterySwitchOffset;
	logic        longitudinalImpedanceSel, scalingBypass, hookState, groundKeyState;
	logic        lowBattery, sampleReadyFlag, dataReadyIrq, pcmTransmitValid;
	logic [31:0] rdv, d;
	int unsigned m[3] = '{32'h1b84b30e, 32'h1108, 0};
	int          num_errors = 0, comparisons = 0, cyc = 0;
	lsfr_regs #(.GK_STEP_CYC(8), .HOOK_STEP_CYC(4), .BAT_CYC(10), .IRQ_NB_CYC(20), .IRQ_WB_CYC(10),
		.SAMPLE_BASE_CYC(64)) dut (.clk, .arst_n, .ce, .hostInData, .hostInValid, .hostInReady, .hostOutData,
		.hostOutValid, .hostOutReady, .hookDetRaw, .gkeyDetRaw, .feedBelowUpper, .feedAboveLower, .testBufferMode,
		.dataReadyIrqArm, .converterDataRate, .wideband, .linearMode, .channelEnableSelect, .transmitPathCut,
		.sampleCh1, .sampleCh2, .groundKeyThreshold, .hookThreshold, .groundKeyDebounce, .hookDebounce,
		.ringTripMethod, .ringTripThreshold, .ringingCurrentLimit, .feedVoltageRangeShift, .openCircuitFeedVoltage,
		.longitudinalImpedanceSel, .batterySwitchOffset, .activeCurrentLimit, .impedanceScalingGain, .scalingBypass,
		.hookState, .groundKeyState, .lowBattery, .sampleReadyFlag, .dataReadyIrq, .pcmTransmitOut, .pcmTransmitValid);
	lsfr_host host (.clk, .hostInReady, .hostOutData, .hostOutValid, .hostInData, .hostInValid, .hostOutReady);
	always #4 clk = ~clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("errors=%0d comparisons=%0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic regs_chk();
		host.rd(8'hc3, 4, rdv);
		chk(rdv, m[0]);
		host.rd(8'hc7, 2, rdv);
		chk(rdv, m[1]);
		host.rd(8'hcb, 1, rdv);
		chk(rdv, m[2]);
		chk({groundKeyThreshold, hookThreshold, groundKeyDebounce, hookDebounce, ringTripMethod, ringTripThreshold,
			3'h0, ringingCurrentLimit}, m[0]);
		chk({1'b0, feedVoltageRangeShift, longitudinalImpedanceSel, openCircuitFeedVoltage, batterySwitchOffset,
			1'b0, activeCurrentLimit}, m[1]);
		chk({scalingBypass, impedanceScalingGain}, {m[2] == 0, m[2][7:0]});
	endtask
	task automatic deb(input int w, input int n, input logic e);
		@(negedge clk);
		if (w == 0) hookDetRaw = 1'b1;
		else gkeyDetRaw = 1'b1;
		repeat (n) @(negedge clk);
		chk(w == 0 ? hookState : groundKeyState, e);
		hookDetRaw = 1'b0;
		gkeyDetRaw = 1'b0;
		repeat (n) @(negedge clk);
		chk(w == 0 ? hookState : groundKeyState, 0);
	endtask
	task automatic wait_irq();
		while (dataReadyIrq !== 1'b0) @(negedge clk);
		while (dataReadyIrq !== 1'b1) @(negedge clk);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		void'($urandom(32'h9d19));
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		regs_chk();
		deb(0, 8, 1'b0);
		deb(0, 40, 1'b1);
		deb(1, 12, 1'b0);
		deb(1, 60, 1'b1);
		feedBelowUpper = 1'b1;
		repeat (6) @(negedge clk);
		feedBelowUpper = 1'b0;
		chk(lowBattery, 0);
		repeat (2) @(negedge clk);
		feedBelowUpper = 1'b1;
		repeat (25) @(negedge clk);
		chk(lowBattery, 1);
		feedBelowUpper = 1'b0;
		feedAboveLower = 1'b1;
		repeat (25) @(negedge clk);
		chk(lowBattery, 0);
		feedAboveLower = 1'b0;
		dataReadyIrqArm = 1'b1;
		for (int i = 0; i < 8; i++) begin
			channelEnableSelect = 2'(i);
			linearMode = i[2];
			transmitPathCut = i[0];
			wideband = 1'($urandom_range(1, 0));
			converterDataRate = 3'($urandom_range(7, 0));
			sampleCh1 = 16'($urandom);
			sampleCh2 = 16'($urandom);
			wait_irq();
			wait_irq();
			chk(sampleReadyFlag, 1);
			host.rd(8'hcd, 2, rdv);
			chk(rdv, (i[1:0] == 2'b10 ? sampleCh2 : sampleCh1) & (i[2] ? 16'hffff : 16'hff00));
			chk({dataReadyIrq, sampleReadyFlag}, 0);
		end
		testBufferMode = 1'b1;
		converterDataRate = 3'h0;
		sampleCh1 = ~sampleCh1;
		ce = 1'b0;
		hookDetRaw = 1'b1;
		repeat (60) @(negedge clk);
		chk(hookState, 0);
		ce = 1'b1;
		repeat (60) @(negedge clk);
		chk(hookState, 1);
		host.rd(8'hcd, 2, d);
		chk(d, rdv);
		chk(pcmTransmitOut, rdv);
		testBufferMode = 1'b0;
		for (int i = 0; i < 6; i++) begin
			d = $urandom & 32'h3fffff1f;
			host.wr(8'hc2, d, 4);
			m[0] = d;
			d = $urandom & 32'h7fdf;
			host.wr(8'hc6, d, 2);
			m[1] = d;
			d = (i == 5) ? 32'h0 : ($urandom & 32'hff);
			host.wr(8'hca, d, 1);
			m[2] = d;
			host.wr(8'h55, 32'h0, 0);
			regs_chk();
		end
		give_verdict();
	end
endmodule
bind lsfr_regs lsfr_regs_asserts #(.HOOK_STEP_CYC(HOOK_STEP_CYC), .BAT_CYC(BAT_CYC), .IRQ_NB_CYC(IRQ_NB_CYC),
	.IRQ_WB_CYC(IRQ_WB_CYC)) u_chk (.clk, .arst_n, .hostInData, .hostInValid, .hostInReady, .hookDetRaw,
	.feedBelowUpper, .feedAboveLower, .testBufferMode, .dataReadyIrqArm, .wideband, .transmitPathCut, .hookDebounce,
	.impedanceScalingGain, .scalingBypass, .hookState, .lowBattery, .sampleReadyFlag, .dataReadyIrq, .pcmTransmitValid);
`default_nettype wire
